// >>> rtl/gdrb_top.sv
// Data register block of a single-axis rate sensor behind a 16/17-bit SPI slave.
// Assumes rate, temperature and monitor inputs come from logic on REF_CLK.
`timescale 1ns/1ps

module gdrb_top
(
  input  wire logic                          REF_CLK,
  input  wire logic                          RESET_N,
  input  wire logic                          SPI_SCK,
  input  wire logic                          SPI_CS_N,
  input  wire logic                          SPI_MOSI,
  output logic                               SPI_MISO,
  output logic                               SPI_MISO_OE,
  input  wire logic [gdrb_pkg::MEAS_W-1:0]   RATE_DATA,
  input  wire logic [gdrb_pkg::MEAS_W-1:0]   TEMP_DATA,
  input  wire logic [gdrb_pkg::MON_W-1:0]    MONITOR_FLAGS
);

  import gdrb_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic odd_par15(input logic [14:0] v);
    return ~(^v);
  endfunction

  function automatic logic [16:0] frame_of(input logic [15:0] w, input logic sel);
    return {w, (^w) ^ sel};
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  gdrb_state_t       st;
  gdrb_state_t       next_st;
  logic [2:0]        pins_s;
  logic              sck_s;
  logic              csn_s;
  logic              mosi_s;
  logic              s_ok;
  logic [15:0]       status_reg;
  logic [15:0]       ident_reg;
  logic [15:0]       rate_reg;
  logic [15:0]       temp_reg;
  logic [15:0]       flags_word;
  logic [16:0]       new_rx;
  logic [15:0]       rx_word;
  logic [6:0]        rx_addr;
  logic              rx_par_ok;
  logic [4:0]        word_len;
  logic [15:0]       rd_value;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  gdrb_sync
  #(
    .W       (3),
    .RST_VAL ({1'b0, CS_N_RST, 1'b0})
  )
  u_sync
  (
    .ref_clk (REF_CLK),
    .reset_n (RESET_N),
    .din     ({SPI_SCK, SPI_CS_N, SPI_MOSI}),
    .dout    (pins_s)
  );

  assign sck_s  = pins_s[2];
  assign csn_s  = pins_s[1];
  assign mosi_s = pins_s[0];

  // ****************************************
  // Register images
  // ****************************************
  always_comb
  begin
    s_ok = (&MONITOR_FLAGS) & st.parity_ok;
    status_reg = {MONITOR_FLAGS[12:7], st.parity_ok, MONITOR_FLAGS[6:0], 2'b00};
    status_reg[0] = odd_par15(status_reg[15:1]);
    ident_reg = 16'h0000;
    ident_reg[IDENT_PAR_EN_BIT] = st.parity_check_enable;
    ident_reg[IDENT_PAR_SEL_BIT] = st.parity_polarity_select;
    ident_reg[0] = odd_par15(ident_reg[15:1]);
    rate_reg = {RATE_DATA, s_ok, odd_par15({1'b0, RATE_DATA[12:0], s_ok})};
    temp_reg = {TEMP_DATA, s_ok, odd_par15({1'b0, TEMP_DATA[12:0], s_ok})};
    flags_word = {14'h0000, s_ok, odd_par15({14'h0000, s_ok})};
  end

  // ****************************************
  // Received word decode
  // ****************************************
  always_comb
  begin
    new_rx = {st.rx[15:0], mosi_s};
    word_len = st.parity_check_enable ? BITS_PARITY : BITS_PLAIN;
    rx_word = st.parity_check_enable ? new_rx[16:1] : new_rx[15:0];
    rx_par_ok = !st.parity_check_enable
                || (((^new_rx[16:1]) ^ new_rx[0]) == st.parity_polarity_select);
    rx_addr = rx_word[CMD_ADDR_MSB:CMD_ADDR_LSB];
    case (rx_addr)
      ADDR_RATE:   rd_value = rate_reg;
      ADDR_IDENT:  rd_value = ident_reg;
      ADDR_STATUS: rd_value = status_reg;
      ADDR_TEMP:   rd_value = temp_reg;
      default:     rd_value = 16'h0000;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_st = st;
    next_st.sck_prev = sck_s;
    next_st.miso_oe = !csn_s;
    if (csn_s)
    begin
      next_st.bit_cnt = 5'h00;
      next_st.phase = GDRB_ADDR_PHASE;
      next_st.tx = frame_of(flags_word, st.parity_polarity_select);
    end
    else if (sck_s && !st.sck_prev)
    begin
      next_st.rx = new_rx;
      next_st.bit_cnt = st.bit_cnt + 5'h01;
      if ((st.bit_cnt + 5'h01) == word_len)
      begin
        next_st.bit_cnt = 5'h00;
        case (st.phase)
          GDRB_ADDR_PHASE:
          begin
            next_st.tx = frame_of(rd_value, st.parity_polarity_select);
            if (!rx_par_ok)
            begin
              next_st.parity_ok = 1'b0;
            end
            else if (!rx_word[CMD_WRITE_BIT] && rx_addr == ADDR_STATUS)
            begin
              next_st.parity_ok = 1'b1;
            end
            if (rx_word[CMD_WRITE_BIT])
            begin
              next_st.phase = GDRB_DATA_PHASE;
              next_st.wr_addr = rx_addr;
              next_st.addr_perr = !rx_par_ok;
            end
          end
          GDRB_DATA_PHASE:
          begin
            next_st.phase = GDRB_ADDR_PHASE;
            next_st.tx = frame_of(flags_word, st.parity_polarity_select);
            if (!rx_par_ok)
            begin
              next_st.parity_ok = 1'b0;
            end
            if (rx_par_ok && !st.addr_perr && st.wr_addr == ADDR_IDENT)
            begin
              next_st.parity_check_enable = rx_word[IDENT_PAR_EN_BIT];
              next_st.parity_polarity_select = rx_word[IDENT_PAR_SEL_BIT];
              next_st.tx = frame_of(flags_word, rx_word[IDENT_PAR_SEL_BIT]);
              if (rx_word[IDENT_SOFT_RST_BIT])
              begin
                next_st = STATE_RST;
                next_st.sck_prev = sck_s;
                next_st.miso_oe = !csn_s;
              end
            end
          end
          default:
          begin
            next_st.phase = GDRB_ADDR_PHASE;
          end
        endcase
      end
    end
    else if (!sck_s && st.sck_prev && st.bit_cnt != 5'h00)
    begin
      next_st.tx = {st.tx[15:0], 1'b0};
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st <= STATE_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign SPI_MISO    = st.tx[16];
  assign SPI_MISO_OE = st.miso_oe;

endmodule // gdrb_top

// >>> pkg/gdrb_pkg.sv
// Constants and types of the gyro data register block.
// Assumes one 20 MHz reference clock and an SPI host on the pins.
package gdrb_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned ADDR_W    = 7;
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned FRAME_W   = 17;
  localparam int unsigned MEAS_W    = 14;
  localparam int unsigned MON_W     = 13;
  localparam int unsigned CNT_W     = 5;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [6:0] ADDR_RATE    = 7'h00;
  localparam logic [6:0] ADDR_IDENT   = 7'h07;
  localparam logic [6:0] ADDR_STATUS  = 7'h08;
  localparam logic [6:0] ADDR_FACTORY = 7'h09;
  localparam logic [6:0] ADDR_TEMP    = 7'h0A;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned CMD_ADDR_LSB       = 3;
  localparam int unsigned CMD_ADDR_MSB       = 9;
  localparam int unsigned CMD_WRITE_BIT      = 2;
  localparam int unsigned IDENT_SOFT_RST_BIT = 3;
  localparam int unsigned IDENT_PAR_EN_BIT   = 12;
  localparam int unsigned IDENT_PAR_SEL_BIT  = 13;
  localparam int unsigned STATUS_PAR_OK_BIT  = 9;

  // ****************************************
  // Counts and reset values
  // ****************************************
  localparam logic [4:0] BITS_PLAIN    = 5'h10;
  localparam logic [4:0] BITS_PARITY   = 5'h11;
  localparam logic       PAR_OK_RST    = 1'b1;
  localparam logic       PAR_EN_RST    = 1'b0;
  localparam logic       PAR_SEL_RST   = 1'b0;
  localparam logic       CS_N_RST      = 1'b1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [0:0]
  {
    GDRB_ADDR_PHASE = 1'b0,
    GDRB_DATA_PHASE = 1'b1
  } gdrb_phase_t;

  typedef struct packed
  {
    logic              sck_prev;
    logic [4:0]        bit_cnt;
    logic [16:0]       rx;
    logic [16:0]       tx;
    gdrb_phase_t       phase;
    logic [6:0]        wr_addr;
    logic              addr_perr;
    logic              parity_ok;
    logic              parity_check_enable;
    logic              parity_polarity_select;
    logic              miso_oe;
  } gdrb_state_t;

  localparam gdrb_state_t STATE_RST = '{
    sck_prev:               1'b0,
    bit_cnt:                5'h00,
    rx:                     17'h00000,
    tx:                     17'h00000,
    phase:                  GDRB_ADDR_PHASE,
    wr_addr:                7'h00,
    addr_perr:              1'b0,
    parity_ok:              PAR_OK_RST,
    parity_check_enable:    PAR_EN_RST,
    parity_polarity_select: PAR_SEL_RST,
    miso_oe:                1'b0
  };

endpackage

// >>> rtl/gdrb_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to ref_clk.
`timescale 1ns/1ps
module gdrb_sync
#(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta;

  // ****************************************
  // Two flip-flops per bit
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta <= RST_VAL;
      dout <= RST_VAL;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // gdrb_sync

// >>> testbench/gdrb_checker.sv
// Port-level timing checks of the gyro data register block.
// Assumes it is bound onto gdrb_top and sampled on REF_CLK.
`timescale 1ns/1ps
module gdrb_checker
(
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic SPI_SCK,
  input wire logic SPI_CS_N,
  input wire logic SPI_MISO,
  input wire logic SPI_MISO_OE
);
  default clocking dc @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);

  // ****************************************
  // Assertions
  // ****************************************
  chk_reset_quiet: assert property (disable iff (1'b0)
    !RESET_N [*2] |-> !SPI_MISO_OE && !SPI_MISO) else $error("Output driven in reset");
  chk_oe_on: assert property ($fell(SPI_CS_N) |-> ##[1:5] SPI_MISO_OE)
    else $error("Output enable late after select");
  chk_oe_off: assert property ($rose(SPI_CS_N) |-> ##[1:5] !SPI_MISO_OE)
    else $error("Output enable late to drop");
  chk_oe_cause: assert property ($rose(SPI_MISO_OE) |-> !$past(SPI_CS_N, 2))
    else $error("Output enable without select");
  chk_oe_lag: assert property ($fell(SPI_CS_N) |-> !SPI_MISO_OE)
    else $error("Output enable ahead of select");
  chk_oe_idle: assert property (SPI_CS_N [*6] |-> !SPI_MISO_OE)
    else $error("Output enabled while idle");
  chk_miso_low: assert property ((!SPI_SCK && !SPI_CS_N) [*8] |-> $stable(SPI_MISO))
    else $error("Data out moved in low phase");
  chk_miso_high: assert property ((SPI_SCK && !SPI_CS_N) [*8] |-> $stable(SPI_MISO))
    else $error("Data out moved in high phase");
endmodule // gdrb_checker

bind gdrb_top gdrb_checker i_gdrb_checker
(
  .REF_CLK     (REF_CLK),
  .RESET_N     (RESET_N),
  .SPI_SCK     (SPI_SCK),
  .SPI_CS_N    (SPI_CS_N),
  .SPI_MISO    (SPI_MISO),
  .SPI_MISO_OE (SPI_MISO_OE)
);

// >>> testbench/gdrb_host_model.sv
// Behavioural SPI host for the gyro data register block.
// Assumes clock idles low and tasks are called just after clk edges.
`timescale 1ns/1ps
module gdrb_host_model
(
  input  wire logic   clk,
  input  wire logic   miso,
  output logic        sck    = 1'b0,
  output logic        cs_n   = 1'b1,
  output logic        mosi   = 1'b0,
  output logic [16:0] rx     = 17'h00000,
  output logic        rx_stb = 1'b0
);
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Close any open frame, then open a new one
  task automatic sel();
    if (cs_n === 1'b0)
    begin
      tick(8);
      cs_n <= 1'b1;
      mosi <= ~mosi;
      tick(12);
    end
    cs_n <= 1'b0;
    tick(8);
  endtask

  // MSB first, parity bit last in parity mode
  task automatic xfer(input logic [16:0] f, input int nb);
    logic [16:0] r;
    r = 17'h00000;
    for (int i = nb - 1; i >= 0; i--)
    begin
      mosi <= f[i];
      tick(8);
      sck <= 1'b1;
      r = {r[15:0], miso};
      tick(8);
      sck <= 1'b0;
    end
    tick(1);
    rx <= r;
    rx_stb <= 1'b1;
    tick(1);
    rx_stb <= 1'b0;
  endtask
endmodule // gdrb_host_model

// >>> testbench/test_gyro_data_register_block.sv
// Self-checking bench of the gyro data register block.
// Assumes package, design, checker and host model compiled first.
`timescale 1ns/1ps
module test_gyro_data_register_block;
  import gdrb_pkg::*;
  logic              ref_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic [MEAS_W-1:0] rate    = '0;
  logic [MEAS_W-1:0] temp    = '0;
  logic [MON_W-1:0]  flg     = '0;
  logic              en      = 1'b0;
  logic              pol     = 1'b0;
  logic              pok     = 1'b1;
  logic [31:0]       seed    = 32'h1497;
  logic              sck, cs_n, mosi, miso, miso_oe, rx_stb;
  logic [16:0]       rx;
  logic [16:0]       q[$];
  logic [15:0]       nxt;
  int                num_errors = 0;
  int                n_tests    = 0;
  logic [6:0]        seq[7] = '{7'h07, 7'h08, 7'h0A, 7'h01, 7'h06, 7'h00, 7'h00};
  // Host writes only control bits of 07h
  logic [31:0]       ops[24] = '{32'h20000000, 32'h10071000, 32'h00070000, 32'h00080000,
    32'h00000000, 32'h20000000, 32'h01070000, 32'h00080000, 32'h00080000, 32'h00000000,
    32'h20000000, 32'h11073001, 32'h12070000, 32'h20000000, 32'h00070000, 32'h10073001,
    32'h00070000, 32'h00000000, 32'h20000000, 32'h10070008, 32'h20000000, 32'h00070000,
    32'h00080000, 32'h00000000};
  wire logic         line = miso_oe ? miso : 1'bz;

  gdrb_top i_gdrb_top (.REF_CLK(ref_clk), .RESET_N(reset_n), .SPI_SCK(sck), .SPI_CS_N(cs_n),
    .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE(miso_oe), .RATE_DATA(rate),
    .TEMP_DATA(temp), .MONITOR_FLAGS(flg));
  gdrb_host_model i_gdrb_host_model (.clk(ref_clk), .miso(line), .sck(sck), .cs_n(cs_n),
    .mosi(mosi), .rx(rx), .rx_stb(rx_stb));

  always #25 ref_clk = ~ref_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] stat();
    return {14'h0000, &flg & pok, ~(&flg & pok)};
  endfunction

  function automatic logic [15:0] rv(input logic [6:0] a);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      ADDR_RATE: v = {rate, &flg & pok, 1'b0};
      ADDR_TEMP: v = {temp, &flg & pok, 1'b0};
      ADDR_IDENT: v = {2'h0, pol, en, 12'h000};
      ADDR_STATUS: v = {flg[12:7], pok, flg[6:0], 2'h0};
      default: v = 16'h0000;
    endcase
    if (a == ADDR_RATE || a == ADDR_TEMP)
      v[0] = ~^v[14:1];
    else if (a == ADDR_IDENT || a == ADDR_STATUS)
      v[0] = ~^v[15:1];
    return v;
  endfunction

  task automatic word(input logic [15:0] w, input logic bad);
    q.push_back(en ? {nxt, ^nxt ^ pol} : {1'b0, nxt});
    i_gdrb_host_model.xfer(en ? {w, ^w ^ pol ^ bad} : {1'b0, w}, en ? 17 : 16);
  endtask

  task automatic rd(input logic [6:0] a, input logic bad);
    word({6'h00, a, 2'h0, ~^a}, bad);
    nxt = rv(a);
    if (bad && en)
      pok = 1'b0;
    else if (a == ADDR_STATUS)
      pok = 1'b1;
  endtask

  // Bad bit 1 spoils the address word, bit 0 the data word
  task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic [1:0] bad);
    word({6'h00, a, 2'h2, ^a}, bad[1]);
    nxt = rv(a);
    if (bad[1] && en)
      pok = 1'b0;
    word(d, bad[0]);
    nxt = stat();
    if (|bad && en)
      pok = 1'b0;
    else if (a == ADDR_IDENT)
      {pok, pol, en} = d[3] ? 3'b100 : {pok, d[13:12]};
  endtask

  task automatic fr();
    i_gdrb_host_model.sel();
    nxt = stat();
  endtask

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED response expected %h seen %h", exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge ref_clk)
    if (rx_stb === 1'b1)
      check(rx, q.pop_front());

  initial
  begin
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    test_done();
  end

  initial
  begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    for (int k = 0; k < 3; k++)
    begin
      seed = lfsr(seed);
      rate <= seed[13:0];
      temp <= seed[29:16];
      flg <= (k == 2) ? 13'h1FFF : seed[31:19];
      @(posedge ref_clk);
      fr();
      foreach (seq[i])
        rd(seq[i], 1'b0);
    end
    foreach (ops[i])
      case (ops[i][31:28])
        4'h0: rd(ops[i][22:16], ops[i][24]);
        4'h1: wr(ops[i][22:16], ops[i][15:0], ops[i][25:24]);
        default: fr();
      endcase
    i_gdrb_host_model.tick(20);
    test_done();
  end
endmodule // test_gyro_data_register_block
